// *** verilog/rst_irq_cfg.svh ***
// Offsets, field positions, control reset value and force read value for the pin request and reset status registers
`ifndef RST_IRQ_CFG_SVH
`define RST_IRQ_CFG_SVH
`define OFF_IRQ_CTRL        2'h0
`define OFF_RST_STATUS      2'h1
`define OFF_DBG_FORCE       2'h2
`define IRQ_MODE_BIT        0
`define IRQ_IE_BIT          1
`define IRQ_ACK_BIT         2
`define IRQ_FLAG_BIT        3
`define IRQ_PE_BIT          4
`define IRQ_RSVD_BIT        5
`define IRQ_PDD_BIT         6
`define RST_LVD_BIT         1
`define RST_BAD_ADDRESS_FLAG_BIT        3
`define RST_BAD_OPCODE_FLAG_BIT        4
`define RST_COP_BIT         5
`define RST_PIN_BIT         6
`define RST_POR_BIT         7
`define FORCE_RESET_BIT     0
`define IRQ_CTRL_RESET      8'h00
`define DBG_READ_VALUE      8'h00
`endif

// *** verilog/rst_irq_pkg.sv ***
// Types shared by the pin request and reset status logic
package rst_irq_pkg;
  typedef enum logic [1:0] {
    RST_KIND_NONE  = 2'h0,
    RST_KIND_POWER = 2'h1,
    RST_KIND_LOWV  = 2'h3,
    RST_KIND_OTHER = 2'h2
  } reset_kind_t;

  typedef struct packed {
    logic ext_pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_address;
  } reset_cause_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       from_debug;
    logic [1:0] addr;
    logic [7:0] wdata;
  } reg_access_t;
endpackage

// *** verilog/irq_pin_and_reset_status_regs.sv ***
// Pin interrupt control, reset source status and debug forced reset registers
//
// Contract
// - Pin enabled: pullup on while pull-disable bit 6 is 0, off when 1.
// - Pin events count only while pin-enable bit 4 is set.
// - Event flag bit 3 set by pin events; software writes do not change it.
// - Writing 1 to acknowledge bit 2 clears the flag; 0 no effect; reads 0.
// - In edge-and-level mode acknowledge cannot clear flag while pin stays low.
// - Interrupt request whenever flag is 1 and enable bit 1 is set.
// - Mode bit 0: 0 falling edges only, 1 falling edges and low level.
// - Debug forced reset clears every reset status flag.
// - Any write to reset status restarts watchdog, flags stay unchanged.
// - Power-on reset sets power-on bit 7 and low-voltage bit 1, clears rest.
// - Low-voltage reset sets bit 1, keeps power-on, clears the four cause flags.
// - Other resets: cause flags follow active sources; power-on and low-voltage cleared.
// - Bad opcode flag bit 4 records illegal opcode resets, incl. disabled stop/background.
// - Bad address flag bit 3 records accesses at unimplemented addresses.
// - Watchdog flag bit 5 records timeouts; source blocked when watchdog option is 0.
// - External pin flag bit 6 records resets from the low reset pin.
// - Force-reset register accepts debug writes only; reads return 0x00.
// - Debug write of 1 to force-reset bit 0 forces a full reset.
`timescale 1ns/100ps
`include "rst_irq_cfg.svh"

module irq_pin_and_reset_status_regs
  import rst_irq_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         reset_n_in,
  // Reset entry report from the system reset controller
  input  wire logic         reset_entry_in,
  input  reset_kind_t       reset_kind_in,
  input  reset_cause_t      reset_cause_in,
  // Reset source qualifiers
  input  wire logic         watchdog_enable_option_in,
  input  wire logic         stop_allow_option_in,
  input  wire logic         background_mode_allow_in,
  input  wire logic         stop_exec_in,
  input  wire logic         enter_debug_instruction_in,
  // Register access from the core or serial debug
  input  reg_access_t       bus_in,
  output logic [7:0]        rdata_out,
  // External interrupt pin
  input  wire logic         irq_pin_in,
  output logic              pin_pullup_enable_out,
  output logic              irq_request_out,
  // Watchdog and reset outputs
  output logic              watchdog_restart_out,
  output logic              force_reset_out,
  output logic              bad_opcode_reset_req_out
);

  logic       pin_sync1_q;
  logic       pin_sync2_q;
  logic       pin_prev_q;
  logic       pin_pull_disable_q;
  logic       pin_request_enable_q;
  logic       pin_event_flag_q;
  logic       pin_interrupt_enable_q;
  logic       pin_detect_mode_q;
  logic [7:0] reset_source_status_q;
  logic       force_reset_q;
  logic       watchdog_restart_q;
  logic [7:0] rdata_q;
  logic       pin_event;
  logic       ack_write;
  logic       ctrl_write;
  logic       status_write;
  logic       force_write;

  function automatic logic hit(input reg_access_t a, input logic [1:0] off);
    hit = a.wr && (a.addr == off);
  endfunction

  assign ctrl_write   = hit(bus_in, `OFF_IRQ_CTRL);
  assign status_write = hit(bus_in, `OFF_RST_STATUS);
  assign force_write  = hit(bus_in, `OFF_DBG_FORCE);
  assign ack_write    = ctrl_write && bus_in.wdata[`IRQ_ACK_BIT];

  // Two flops so detection never sees a metastable pin level
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      pin_sync1_q <= 1'b1;
      pin_sync2_q <= 1'b1;
      pin_prev_q  <= 1'b1;
    end else begin
      pin_sync1_q <= irq_pin_in;
      pin_sync2_q <= pin_sync1_q;
      pin_prev_q  <= pin_sync2_q;
    end
  end

  // Falling edge, or held low when level mode is on
  assign pin_event = pin_request_enable_q &&
                     ((pin_prev_q && !pin_sync2_q) ||
                      (pin_detect_mode_q && !pin_sync2_q));

  // Control bits; reserved bit 5 is dropped, so a wrong write is harmless
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      pin_pull_disable_q     <= 1'b0;
      pin_request_enable_q   <= 1'b0;
      pin_interrupt_enable_q <= 1'b0;
      pin_detect_mode_q      <= 1'b0;
    end else if (ctrl_write) begin
      pin_pull_disable_q     <= bus_in.wdata[`IRQ_PDD_BIT];
      pin_request_enable_q   <= bus_in.wdata[`IRQ_PE_BIT];
      pin_interrupt_enable_q <= bus_in.wdata[`IRQ_IE_BIT];
      pin_detect_mode_q      <= bus_in.wdata[`IRQ_MODE_BIT];
    end
  end

  // Event wins over an acknowledge in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      pin_event_flag_q <= 1'b0;
    end else if (pin_event) begin
      pin_event_flag_q <= 1'b1;
    end else if (ack_write) begin
      pin_event_flag_q <= 1'b0;
    end
  end

  assign irq_request_out       = pin_event_flag_q && pin_interrupt_enable_q;
  assign pin_pullup_enable_out = pin_request_enable_q && !pin_pull_disable_q;

  // Status flags are loaded on reset entry, so they survive the reset itself
  always_ff @(posedge clk_sys_in) begin
    if (force_reset_q) begin
      reset_source_status_q <= 8'h00;
    end else if (reset_entry_in) begin
      unique case (reset_kind_in)
        RST_KIND_POWER: begin
          reset_source_status_q                <= 8'h00;
          reset_source_status_q[`RST_POR_BIT]  <= 1'b1;
          reset_source_status_q[`RST_LVD_BIT]  <= 1'b1;
        end
        RST_KIND_LOWV: begin
          reset_source_status_q[`RST_PIN_BIT]  <= 1'b0;
          reset_source_status_q[`RST_COP_BIT]  <= 1'b0;
          reset_source_status_q[`RST_BAD_OPCODE_FLAG_BIT] <= 1'b0;
          reset_source_status_q[`RST_BAD_ADDRESS_FLAG_BIT] <= 1'b0;
          reset_source_status_q[`RST_LVD_BIT]  <= 1'b1;
        end
        RST_KIND_OTHER: begin
          reset_source_status_q                <= 8'h00;
          reset_source_status_q[`RST_PIN_BIT]  <= reset_cause_in.ext_pin;
          reset_source_status_q[`RST_COP_BIT]  <= reset_cause_in.watchdog &&
                                                  watchdog_enable_option_in;
          reset_source_status_q[`RST_BAD_OPCODE_FLAG_BIT] <= reset_cause_in.bad_opcode;
          reset_source_status_q[`RST_BAD_ADDRESS_FLAG_BIT] <= reset_cause_in.bad_address;
        end
        RST_KIND_NONE: begin
          reset_source_status_q <= reset_source_status_q;
        end
      endcase
    end
  end

  // Disabled stop or background instructions are illegal opcodes
  assign bad_opcode_reset_req_out = (stop_exec_in && !stop_allow_option_in) ||
                                    (enter_debug_instruction_in && !background_mode_allow_in);

  // Status write only restarts the watchdog
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      watchdog_restart_q <= 1'b0;
    end else begin
      watchdog_restart_q <= status_write;
    end
  end

  // Only serial debug writes may force the reset
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      force_reset_q <= 1'b0;
    end else begin
      force_reset_q <= force_write && bus_in.from_debug &&
                       bus_in.wdata[`FORCE_RESET_BIT];
    end
  end

  assign watchdog_restart_out = watchdog_restart_q;
  assign force_reset_out      = force_reset_q;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        `OFF_IRQ_CTRL:   rdata_q <= {1'b0, pin_pull_disable_q, 1'b0, pin_request_enable_q,
                                     pin_event_flag_q, 1'b0, pin_interrupt_enable_q,
                                     pin_detect_mode_q};
        `OFF_RST_STATUS: rdata_q <= reset_source_status_q;
        `OFF_DBG_FORCE:  rdata_q <= `DBG_READ_VALUE;
        default:         rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata_out = rdata_q;

  // Level mode: a held-low pin re-sets the flag, so acknowledge cannot clear it
  chk_level_holds_flag: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_request_enable_q && pin_detect_mode_q && !pin_sync2_q |=> pin_event_flag_q)
    else $error("flag cleared while pin held low in level mode");

  chk_ack_clears_flag: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ack_write && !pin_event |=> !pin_event_flag_q)
    else $error("acknowledge did not clear flag");

  chk_edge_sets_flag: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_request_enable_q && $fell(pin_sync2_q) |=> pin_event_flag_q)
    else $error("falling edge did not set flag");

  chk_disabled_no_event: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !pin_request_enable_q && !pin_event_flag_q && !ack_write && !ctrl_write |=> !pin_event_flag_q)
    else $error("flag set while pin disabled");

  chk_irq_follows_flag: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    irq_request_out == (pin_event_flag_q && pin_interrupt_enable_q))
    else $error("interrupt request mismatch");

  chk_pullup_control: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_request_enable_q && pin_pull_disable_q |-> !pin_pullup_enable_out)
    else $error("pullup on while disabled");

  chk_user_force_ignored: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    force_write && !bus_in.from_debug |=> !force_reset_out)
    else $error("user write forced reset");

  chk_force_clears_status: assert property (@(posedge clk_sys_in)
    force_reset_out |=> reset_source_status_q == 8'h00)
    else $error("forced reset left status flags");

  chk_status_write_keeps: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    status_write && !reset_entry_in && !force_reset_q |=> watchdog_restart_out && $stable(reset_source_status_q))
    else $error("status write changed flags or missed restart");

  chk_power_on_flags: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_POWER && !force_reset_q |=> reset_source_status_q == 8'h82)
    else $error("power-on flags wrong");

  chk_watchdog_blocked: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_OTHER && !watchdog_enable_option_in && !force_reset_q
    |=> !reset_source_status_q[`RST_COP_BIT])
    else $error("watchdog flag set while disabled");

  chk_edge_only_mode: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_request_enable_q && !pin_detect_mode_q && !pin_prev_q && !pin_sync2_q && !pin_event_flag_q |=> !pin_event_flag_q)
    else $error("low level set flag in edge-only mode");

  chk_flag_write_ignored: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ctrl_write && !bus_in.wdata[`IRQ_ACK_BIT] && !pin_event |=> $stable(pin_event_flag_q))
    else $error("control write changed flag");

  chk_ctrl_read_zeros: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    bus_in.rd && bus_in.addr == `OFF_IRQ_CTRL |=> !rdata_out[`IRQ_ACK_BIT] && !rdata_out[`IRQ_RSVD_BIT] && !rdata_out[7])
    else $error("acknowledge or reserved bit read as one");

  chk_ctrl_readback: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    bus_in.rd && bus_in.addr == `OFF_IRQ_CTRL |=> rdata_out[`IRQ_PE_BIT] == $past(pin_request_enable_q))
    else $error("pin enable readback wrong");

  chk_mode_readback: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    bus_in.rd && bus_in.addr == `OFF_IRQ_CTRL |=> rdata_out[`IRQ_MODE_BIT] == $past(pin_detect_mode_q))
    else $error("detect mode readback wrong");

  chk_force_reads_zero: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    bus_in.rd && bus_in.addr == `OFF_DBG_FORCE |=> rdata_out == `DBG_READ_VALUE)
    else $error("force register read not zero");

  chk_status_readback: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    bus_in.rd && bus_in.addr == `OFF_RST_STATUS |=> rdata_out == $past(reset_source_status_q))
    else $error("status readback wrong");

  chk_irq_off_polling: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !pin_interrupt_enable_q |-> !irq_request_out)
    else $error("request raised with interrupt disabled");

  chk_pullup_on: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_request_enable_q && !pin_pull_disable_q |-> pin_pullup_enable_out)
    else $error("pullup off while enabled");

  chk_lowv_flags: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_LOWV && !force_reset_q |=>
    reset_source_status_q[`RST_PIN_BIT:`RST_BAD_ADDRESS_FLAG_BIT] == 4'h0 && reset_source_status_q[`RST_LVD_BIT])
    else $error("low-voltage flags wrong");

  chk_other_clears_por: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_OTHER && !force_reset_q |=>
    !reset_source_status_q[`RST_POR_BIT] && !reset_source_status_q[`RST_LVD_BIT])
    else $error("power-on or low-voltage flag left set");

  chk_pin_cause: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_OTHER && !force_reset_q |=>
    reset_source_status_q[`RST_PIN_BIT] == $past(reset_cause_in.ext_pin))
    else $error("pin flag wrong");

  chk_opcode_cause: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_OTHER && !force_reset_q |=>
    reset_source_status_q[`RST_BAD_OPCODE_FLAG_BIT] == $past(reset_cause_in.bad_opcode))
    else $error("bad opcode flag wrong");

  chk_address_cause: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_OTHER && !force_reset_q |=>
    reset_source_status_q[`RST_BAD_ADDRESS_FLAG_BIT] == $past(reset_cause_in.bad_address))
    else $error("bad address flag wrong");

  chk_watchdog_cause: assert property (@(posedge clk_sys_in)
    reset_entry_in && reset_kind_in == RST_KIND_OTHER && watchdog_enable_option_in && !force_reset_q |=>
    reset_source_status_q[`RST_COP_BIT] == $past(reset_cause_in.watchdog))
    else $error("watchdog flag wrong");

  chk_debug_force: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    force_write && bus_in.from_debug && bus_in.wdata[`FORCE_RESET_BIT] |=> force_reset_out)
    else $error("debug write did not force reset");

  chk_force_needs_debug: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    force_reset_out |-> $past(force_write && bus_in.from_debug))
    else $error("forced reset without debug write");

  chk_restart_needs_write: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    watchdog_restart_out |-> $past(status_write))
    else $error("restart without status write");

  chk_sync_chain: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_sync2_q == $past(pin_sync1_q))
    else $error("synchroniser skipped a stage");

  chk_stop_illegal: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    stop_exec_in && !stop_allow_option_in |-> bad_opcode_reset_req_out)
    else $error("disabled stop not flagged");

  chk_enter_debug_instruction_illegal: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    enter_debug_instruction_in && !background_mode_allow_in |-> bad_opcode_reset_req_out)
    else $error("disabled background instruction not flagged");

  chk_opcode_quiet: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !stop_exec_in && !enter_debug_instruction_in |-> !bad_opcode_reset_req_out)
    else $error("bad opcode request without instruction");

  chk_event_sets_flag: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_event |=> pin_event_flag_q)
    else $error("event did not set flag");

  chk_flag_holds: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_event_flag_q && !ack_write |=> pin_event_flag_q)
    else $error("flag dropped without acknowledge");

  cov_edge_event: cover property (@(posedge clk_sys_in) pin_request_enable_q && $fell(pin_sync2_q));
  cov_ack_clear: cover property (@(posedge clk_sys_in) pin_event_flag_q ##1 !pin_event_flag_q);
  cov_debug_force: cover property (@(posedge clk_sys_in) force_reset_out);
  cov_irq_request: cover property (@(posedge clk_sys_in) irq_request_out);
  cov_level_hold: cover property (@(posedge clk_sys_in) pin_detect_mode_q && !pin_sync2_q && ack_write);

endmodule

// *** bench/irq_pin_model.sv ***
// Model of the external interrupt pin and the debug host mode pin
`timescale 1ns/100ps
module irq_pin_model (
  // Bench control
  input  wire logic clk_sys_in,
  input  wire logic drive_low_in,
  input  wire logic pullup_in,
  input  wire logic user_mode_in,
  // Pin levels
  output logic      pin_out,
  output logic      mode_pin_out
);
  logic float_q = 1'b1;
  // A floating pin toggles so a stale level can never look valid
  always_ff @(posedge clk_sys_in) begin
    float_q <= ~float_q;
  end
  assign pin_out = drive_low_in ? 1'b0 : (pullup_in ? 1'b1 : float_q);
  // Held high after a forcing write to come back in user mode
  assign mode_pin_out = user_mode_in;
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the pin request and reset status registers
`timescale 1ns/100ps
`include "rst_irq_cfg.svh"
module tb_top import rst_irq_pkg::*; ;
  logic         clk_sys_in = 1'b0;
  logic         reset_n_in = 1'b0;
  logic         entry = 1'b0;
  logic         wd_opt = 1'b1;
  logic         stop_opt = 1'b1;
  logic         enter_debug_instruction_opt = 1'b1;
  logic         stop_ex = 1'b0;
  logic         enter_debug_instruction_ex = 1'b0;
  logic         drv_low = 1'b0;
  logic         user_mode = 1'b1;
  reset_kind_t  kind = RST_KIND_NONE;
  reset_cause_t cause = 4'h0;
  reg_access_t  bus = '0;
  logic [7:0]   rdata_out;
  logic [7:0]   v;
  logic         pull, irq, restart, force_rst, bad_op, pin;
  int           mismatches = 0;
  int           cmp_count = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  irq_pin_and_reset_status_regs uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .reset_entry_in(entry),
    .reset_kind_in(kind), .reset_cause_in(cause), .watchdog_enable_option_in(wd_opt),
    .stop_allow_option_in(stop_opt), .background_mode_allow_in(enter_debug_instruction_opt), .stop_exec_in(stop_ex),
    .enter_debug_instruction_in(enter_debug_instruction_ex), .bus_in(bus), .rdata_out(rdata_out), .irq_pin_in(pin),
    .pin_pullup_enable_out(pull), .irq_request_out(irq), .watchdog_restart_out(restart),
    .force_reset_out(force_rst), .bad_opcode_reset_req_out(bad_op));

  irq_pin_model host (
    .clk_sys_in(clk_sys_in), .drive_low_in(drv_low), .pullup_in(pull),
    .user_mode_in(user_mode), .pin_out(pin), .mode_pin_out());

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic dbg);
    @(negedge clk_sys_in);
    bus = '{wr: 1'b1, rd: 1'b0, from_debug: dbg, addr: a, wdata: d};
    @(negedge clk_sys_in);
    bus.wr = 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(negedge clk_sys_in);
    bus = '{wr: 1'b0, rd: 1'b1, from_debug: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk_sys_in);
    bus.rd = 1'b0;
    v = rdata_out;
  endtask

  task automatic enter(input reset_kind_t k, input reset_cause_t c);
    @(negedge clk_sys_in);
    entry = 1'b1;
    kind = k;
    cause = c;
    @(negedge clk_sys_in);
    entry = 1'b0;
  endtask

  // Two sync stages stand between the pin and the flag
  task automatic pin_low(input logic low);
    @(negedge clk_sys_in);
    drv_low = low;
    repeat (4) @(negedge clk_sys_in);
  endtask

  task automatic t_status;
    enter(RST_KIND_POWER, 4'h0);
    rd(`OFF_RST_STATUS);
    check("por", v, 8'h82);
    enter(RST_KIND_LOWV, 4'hF);
    rd(`OFF_RST_STATUS);
    check("lowv", v, 8'h82);
    wd_opt = 1'b0;
    enter(RST_KIND_OTHER, 4'hD);
    rd(`OFF_RST_STATUS);
    check("pin_addr", v, 8'h48);
    wd_opt = 1'b1;
    enter(RST_KIND_OTHER, 4'h6);
    rd(`OFF_RST_STATUS);
    check("wdog_op", v, 8'h30);
    wr(`OFF_RST_STATUS, 8'hFF, 1'b0);
    check("restart", restart, 8'h01);
    rd(`OFF_RST_STATUS);
    check("kept", v, 8'h30);
  endtask

  task automatic t_force;
    wr(`OFF_DBG_FORCE, 8'h01, 1'b0);
    check("user_force", force_rst, 8'h00);
    rd(`OFF_DBG_FORCE);
    check("force_rd", v, 8'h00);
    rd(2'h3);
    check("unmapped", v, 8'h00);
    wr(`OFF_DBG_FORCE, 8'h01, 1'b1);
    check("dbg_force", force_rst, 8'h01);
    rd(`OFF_RST_STATUS);
    check("cleared", v, 8'h00);
  endtask

  task automatic t_irq_edge;
    // The floating pin may leave a false edge in the synchroniser; let it settle, then acknowledge
    wr(`OFF_IRQ_CTRL, 8'h10, 1'b0);
    repeat (3) @(negedge clk_sys_in);
    wr(`OFF_IRQ_CTRL, 8'h16, 1'b0);
    rd(`OFF_IRQ_CTRL);
    check("ctrl", v, 8'h12);
    check("pull_on", pull, 8'h01);
    pin_low(1'b1);
    check("irq", irq, 8'h01);
    rd(`OFF_IRQ_CTRL);
    check("flag", v, 8'h1A);
    wr(`OFF_IRQ_CTRL, 8'h16, 1'b0);
    rd(`OFF_IRQ_CTRL);
    check("ack", v, 8'h12);
    wr(`OFF_IRQ_CTRL, 8'h1A, 1'b0);
    rd(`OFF_IRQ_CTRL);
    check("flag_wr", v, 8'h12);
    pin_low(1'b0);
    wr(`OFF_IRQ_CTRL, 8'h10, 1'b0);
    pin_low(1'b1);
    check("polled", irq, 8'h00);
    rd(`OFF_IRQ_CTRL);
    check("poll_flag", v, 8'h18);
  endtask

  task automatic t_irq_level;
    pin_low(1'b0);
    wr(`OFF_IRQ_CTRL, 8'h13, 1'b0);
    wr(`OFF_IRQ_CTRL, 8'h17, 1'b0);
    rd(`OFF_IRQ_CTRL);
    check("lvl_idle", v, 8'h13);
    pin_low(1'b1);
    wr(`OFF_IRQ_CTRL, 8'h17, 1'b0);
    rd(`OFF_IRQ_CTRL);
    check("lvl_hold", v, 8'h1B);
    pin_low(1'b0);
    wr(`OFF_IRQ_CTRL, 8'h17, 1'b0);
    rd(`OFF_IRQ_CTRL);
    check("lvl_clr", v, 8'h13);
    wr(`OFF_IRQ_CTRL, 8'h02, 1'b0);
    pin_low(1'b1);
    rd(`OFF_IRQ_CTRL);
    check("pin_off", v, 8'h02);
    wr(`OFF_IRQ_CTRL, 8'h53, 1'b0);
    check("pull_off", pull, 8'h00);
  endtask

  task automatic t_opcode;
    @(negedge clk_sys_in);
    stop_opt = 1'b0;
    stop_ex = 1'b1;
    #1 check("stop_bad", bad_op, 8'h01);
    stop_opt = 1'b1;
    #1 check("stop_ok", bad_op, 8'h00);
    stop_ex = 1'b0;
    enter_debug_instruction_opt = 1'b0;
    enter_debug_instruction_ex = 1'b1;
    #1 check("enter_debug_instruction_bad", bad_op, 8'h01);
    enter_debug_instruction_opt = 1'b1;
    #1 check("enter_debug_instruction_ok", bad_op, 8'h00);
    enter_debug_instruction_ex = 1'b0;
  endtask

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    t_status;
    t_force;
    t_irq_edge;
    t_irq_level;
    t_opcode;
    finish_test;
  end

  // The sequence needs about 120 cycles; this allows over thirty times that
  initial begin
    #400000;
    mismatches++;
    finish_test;
  end
endmodule
